// ===== verilog/nisl_top.sv
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "nisl_cfg.svh"
module nisl_top #(
   parameter logic [`NISL_WDOG_W-1:0] WDOG_CYCLES = `NISL_WDOG_CYCLES,
   parameter int MARK_W = `NISL_MARK_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`NISL_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [`NISL_DAT_W-1:0] wb_dat_i,
   output logic [`NISL_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_half_i,
   input wire logic rx_full_i,
   input wire logic tx_half_i,
   input wire logic dram_rd_done_i,
   input wire logic [`NISL_PAR_BYTES-1:0] byte_parity_ok_i,
   input wire logic bus_busy_i,
   input wire logic marker_count_enable_i,
   input wire logic marker_count_dir_i,
   input wire logic network_module_irq_i,
   input wire logic mgmt_unit_irq_n_i,
   input wire logic expansion_irq_i,
   output logic cpu_irq_synced_o
);
   localparam nisl_pkg::nisl_state_t RST_STATE = '{
      ack: 1'b0,
      dat: '0,
      mask: `NISL_MASK_RST,
      rx_half_latched: 1'b0,
      tx_half_latched: 1'b0,
      rx_full_latched: 1'b0,
      parity_detect_latched: 1'b0,
      parity_err_irq: 1'b0,
      bus_timeout_flag: 1'b0,
      wdog_cnt: '0,
      irq_sync1: 1'b0,
      irq_sync2: 1'b0
   };

   nisl_pkg::nisl_state_t state_ff;
   nisl_pkg::nisl_state_t nxt_state;

   logic marker_in_rx_fifo;
   logic parity_error_detect;
   logic serial_irq;
   logic rx_level_irq;
   logic tx_level_irq;
   logic timeout_interval_carry;
   logic combined_irq_raw;
   logic bus_req;
   logic bus_commit;
   logic ctl_sel;
   logic clr_sel;
   logic parity_clear_strobe;
   logic bus_timeout_clear;
   logic [`NISL_DAT_W-1:0] status_word;

   // source passes only while its mask bit is clear
   function automatic logic gate(input logic src, input logic mask_bit);
      gate = src & ~mask_bit;
   endfunction

   nisl_marker_counter #(
      .CNT_W(MARK_W)
   ) u_marker_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .marker_count_enable_i(marker_count_enable_i),
      .marker_count_dir_i(marker_count_dir_i),
      .has_message_o(marker_in_rx_fifo)
   );

   // any failing byte on a finished read
   assign parity_error_detect = dram_rd_done_i & ~(&byte_parity_ok_i);

   // management input is active low
   assign serial_irq = network_module_irq_i | ~mgmt_unit_irq_n_i;

   assign rx_level_irq = state_ff.rx_half_latched | marker_in_rx_fifo;
   assign tx_level_irq = ~state_ff.tx_half_latched;

   assign timeout_interval_carry = bus_busy_i &&
      (state_ff.wdog_cnt == WDOG_CYCLES - 1'b1);

   // marker term carries both the rx and the marker masks
   assign combined_irq_raw =
      gate(state_ff.rx_half_latched, state_ff.mask[`NISL_CTL_RX]) |
      gate(gate(marker_in_rx_fifo, state_ff.mask[`NISL_CTL_RX]),
           state_ff.mask[`NISL_CTL_MARK]) |
      gate(tx_level_irq, state_ff.mask[`NISL_CTL_TX]) |
      gate(state_ff.parity_err_irq, state_ff.mask[`NISL_CTL_HW]) |
      gate(state_ff.bus_timeout_flag, state_ff.mask[`NISL_CTL_HW]) |
      gate(serial_irq, state_ff.mask[`NISL_CTL_SER]) |
      gate(expansion_irq_i, state_ff.mask[`NISL_CTL_EXP]);

   // bus request is answered one edge later; writes land on the edge
   // where the master sees ack; a request held past ack is acked and written again every second edge
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_commit = bus_req & state_ff.ack & wb_we_i;
   assign ctl_sel = (wb_adr_i == `NISL_OFS_CTRL);
   assign clr_sel = (wb_adr_i == `NISL_OFS_CLR);
   assign parity_clear_strobe = bus_commit & clr_sel & wb_sel_i[0] &
      wb_dat_i[`NISL_CLR_PAR];
   assign bus_timeout_clear = bus_commit & clr_sel & wb_sel_i[0] &
      wb_dat_i[`NISL_CLR_BUS];

   always_comb begin
      status_word = '0;
      status_word[`NISL_ST_RXHALF] = state_ff.rx_half_latched;
      status_word[`NISL_ST_TXHALF] = state_ff.tx_half_latched;
      status_word[`NISL_ST_RXFULL] = state_ff.rx_full_latched;
      status_word[`NISL_ST_MARK] = marker_in_rx_fifo;
      status_word[`NISL_ST_PARIRQ] = state_ff.parity_err_irq;
      status_word[`NISL_ST_BUSTO] = state_ff.bus_timeout_flag;
      status_word[`NISL_ST_PARLAT] = state_ff.parity_detect_latched;
      status_word[`NISL_ST_SER] = serial_irq;
      status_word[`NISL_ST_EXP] = expansion_irq_i;
      status_word[`NISL_ST_RAW] = combined_irq_raw;
      status_word[`NISL_ST_CPU] = state_ff.irq_sync2;
      status_word[`NISL_ST_RXIRQ] = rx_level_irq;
      status_word[`NISL_ST_TXIRQ] = tx_level_irq;
   end

   always_comb begin
      nxt_state = state_ff;

      // bus slave: ack drops the cycle after it is given
      nxt_state.ack = bus_req & ~state_ff.ack;
      if (bus_req && !state_ff.ack) begin
         unique case (wb_adr_i)
            `NISL_OFS_CTRL: nxt_state.dat = {{(`NISL_DAT_W-`NISL_MASK_W){1'b0}}, state_ff.mask};
            `NISL_OFS_STAT: nxt_state.dat = status_word;
            default: nxt_state.dat = '0;
         endcase
      end
      if (bus_commit && ctl_sel && wb_sel_i[0]) begin
         nxt_state.mask = wb_dat_i[`NISL_MASK_W-1:0];
      end

      // level flags sampled once per cycle
      nxt_state.rx_half_latched = rx_half_i;
      nxt_state.tx_half_latched = tx_half_i;
      nxt_state.rx_full_latched = rx_full_i;

      // only a clean finished read releases the detect latch
      if (parity_error_detect) begin
         nxt_state.parity_detect_latched = 1'b1;
      end else if (dram_rd_done_i) begin
         nxt_state.parity_detect_latched = 1'b0;
      end

      // a new error in the clearing cycle keeps the flag set
      nxt_state.parity_err_irq = parity_error_detect |
         (state_ff.parity_err_irq & ~parity_clear_strobe);

      // watchdog restarts whenever the bus goes idle
      if (!bus_busy_i || timeout_interval_carry) begin
         nxt_state.wdog_cnt = '0;
      end else begin
         nxt_state.wdog_cnt = state_ff.wdog_cnt + 1'b1;
      end
      nxt_state.bus_timeout_flag = timeout_interval_carry |
         (state_ff.bus_timeout_flag & ~bus_timeout_clear);

      // first stage feeds only the second
      nxt_state.irq_sync1 = combined_irq_raw;
      nxt_state.irq_sync2 = state_ff.irq_sync1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= RST_STATE;
      end else if (ce_i) begin
         state_ff <= nxt_state;
      end
   end

   assign wb_dat_o = state_ff.dat;
   assign wb_ack_o = state_ff.ack;
   assign cpu_irq_synced_o = state_ff.irq_sync2;
endmodule
`default_nettype wire

// ===== verilog/nisl_cfg.svh
`ifndef NISL_CFG_SVH
`define NISL_CFG_SVH
// register byte offsets
`define NISL_OFS_CTRL 8'h00
`define NISL_OFS_STAT 8'h04
`define NISL_OFS_CLR 8'h08
// control register field positions
`define NISL_CTL_HW 0
`define NISL_CTL_RX 1
`define NISL_CTL_MARK 2
`define NISL_CTL_TX 3
`define NISL_CTL_SER 4
`define NISL_CTL_EXP 5
`define NISL_MASK_W 6
`define NISL_MASK_RST 6'h3f
// clear register field positions
`define NISL_CLR_PAR 0
`define NISL_CLR_BUS 1
// status register field positions
`define NISL_ST_RXHALF 0
`define NISL_ST_TXHALF 1
`define NISL_ST_RXFULL 2
`define NISL_ST_MARK 3
`define NISL_ST_PARIRQ 4
`define NISL_ST_BUSTO 5
`define NISL_ST_PARLAT 6
`define NISL_ST_SER 7
`define NISL_ST_EXP 8
`define NISL_ST_RAW 9
`define NISL_ST_CPU 10
`define NISL_ST_RXIRQ 11
`define NISL_ST_TXIRQ 12
// widths and counts
`define NISL_DAT_W 32
`define NISL_ADR_W 8
`define NISL_WDOG_W 16
`define NISL_WDOG_CYCLES 16'h0100
`define NISL_MARK_W 8
`define NISL_PAR_BYTES 8
`endif

// ===== verilog/nisl_pkg.sv
`include "nisl_cfg.svh"
package nisl_pkg;
   typedef struct packed {
      logic ack;
      logic [`NISL_DAT_W-1:0] dat;
      logic [`NISL_MASK_W-1:0] mask;
      logic rx_half_latched;
      logic tx_half_latched;
      logic rx_full_latched;
      logic parity_detect_latched;
      logic parity_err_irq;
      logic bus_timeout_flag;
      logic [`NISL_WDOG_W-1:0] wdog_cnt;
      logic irq_sync1;
      logic irq_sync2;
   } nisl_state_t;

   typedef struct packed {
      logic [`NISL_MARK_W-1:0] cnt;
      logic has_message;
   } nisl_cnt_state_t;
endpackage

// ===== verilog/nisl_marker_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "nisl_cfg.svh"
module nisl_marker_counter #(
   parameter int CNT_W = `NISL_MARK_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic marker_count_enable_i,
   input wire logic marker_count_dir_i,
   output logic has_message_o
);
   nisl_pkg::nisl_cnt_state_t state_ff;
   nisl_pkg::nisl_cnt_state_t nxt_state;
   logic [CNT_W-1:0] cnt_max;

   assign cnt_max = {CNT_W{1'b1}};

   always_comb begin
      nxt_state = state_ff;
      // saturate both ways so a stray strobe cannot wrap the count
      if (marker_count_enable_i) begin
         if (marker_count_dir_i && state_ff.cnt != cnt_max) begin
            nxt_state.cnt = state_ff.cnt + 1'b1;
         end else if (!marker_count_dir_i && state_ff.cnt != '0) begin
            nxt_state.cnt = state_ff.cnt - 1'b1;
         end
      end
      nxt_state.has_message = (nxt_state.cnt != '0);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else if (ce_i) begin
         state_ff <= nxt_state;
      end
   end

   assign has_message_o = state_ff.has_message;
endmodule
`default_nettype wire

// ===== test/nisl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "nisl_cfg.svh"
module nisl_chk #(
   parameter logic [`NISL_WDOG_W-1:0] WDOG_CYCLES = `NISL_WDOG_CYCLES,
   parameter int MARK_W = `NISL_MARK_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_we_i,
   input wire logic [`NISL_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [`NISL_DAT_W-1:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic rx_half_i,
   input wire logic tx_half_i,
   input wire logic dram_rd_done_i,
   input wire logic [`NISL_PAR_BYTES-1:0] byte_parity_ok_i,
   input wire logic bus_busy_i,
   input wire logic network_module_irq_i,
   input wire logic mgmt_unit_irq_n_i,
   input wire logic expansion_irq_i,
   input wire logic cpu_irq_synced_o
);
   // mask mirror commits on the ack edge, as the design does
   logic [5:0] msk_ff;
   int busy_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msk_ff <= 6'h3f;
         busy_ff <= 0;
      end else begin
         if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `NISL_OFS_CTRL) begin
            msk_ff <= wb_dat_i[5:0];
         end
         // bus idle so no clear can slip in while counting
         busy_ff <= (bus_busy_i && !msk_ff[0] && !wb_cyc_i) ? busy_ff + 1 : 0;
      end
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_exp; (expansion_irq_i && !msk_ff[5]) [*2] |=> cpu_irq_synced_o; endproperty
   a_exp: assert property (p_exp) else $error("expansion irq lost");
   property p_net; (network_module_irq_i && !msk_ff[4]) [*2] |=> cpu_irq_synced_o; endproperty
   a_net: assert property (p_net) else $error("network irq lost");
   property p_mgt; (!mgmt_unit_irq_n_i && !msk_ff[4]) [*2] |=> cpu_irq_synced_o; endproperty
   a_mgt: assert property (p_mgt) else $error("mgmt irq lost");
   property p_tx; (!tx_half_i && !msk_ff[3]) [*4] |=> cpu_irq_synced_o; endproperty
   a_tx: assert property (p_tx) else $error("tx irq lost");
   property p_rx; (rx_half_i && !msk_ff[1]) [*4] |=> cpu_irq_synced_o; endproperty
   a_rx: assert property (p_rx) else $error("rx irq lost");
   property p_par; dram_rd_done_i && !(&byte_parity_ok_i) && !msk_ff[0]
      ##1 (!msk_ff[0] && !wb_cyc_i) [*3] |=> cpu_irq_synced_o; endproperty
   a_par: assert property (p_par) else $error("parity irq lost");
   property p_tmo; busy_ff >= WDOG_CYCLES + 3 |-> cpu_irq_synced_o; endproperty
   a_tmo: assert property (p_tmo) else $error("timeout irq lost");
   property p_all; (msk_ff == 6'h3f) [*3] |=> !cpu_irq_synced_o; endproperty
   a_all: assert property (p_all) else $error("masked irq leaked");
endmodule
`default_nettype wire

// ===== test/nisl_host.sv
`timescale 1ns/1ps
`default_nettype none
module nisl_host (
   input wire logic clk_i,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   logic tmo = 1'h0;
   initial begin
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
   end
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_o <= 1'h1;
      wb_stb_o <= 1'h1;
      wb_we_o <= we;
      wb_adr_o <= a;
      wb_sel_o <= 4'hf;
      wb_dat_o <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_i !== 1'h1 && n < 50);
      tmo = (wb_ack_i !== 1'h1);
      q = wb_dat_i;
      wb_cyc_o <= 1'h0;
      wb_stb_o <= 1'h0;
      wb_we_o <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ===== test/node_interrupt_status_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "nisl_cfg.svh"
module node_interrupt_status_logic_test;
   localparam logic [15:0] WD = 16'h0004;
   logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, dram_rd_done_i = 1'h0, bus_busy_i = 1'h0;
   logic marker_count_enable_i = 1'h0, marker_count_dir_i = 1'h0;
   logic [7:0] byte_parity_ok_i = 8'hff;
   logic [5:0] src = 6'h14;
   logic [31:0] q;
   wire logic rx_half_i, rx_full_i, tx_half_i, network_module_irq_i, mgmt_unit_irq_n_i, expansion_irq_i;
   wire logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_irq_synced_o;
   wire logic [7:0] wb_adr_i;
   wire logic [3:0] wb_sel_i;
   wire logic [31:0] wb_dat_i, wb_dat_o;
   int error_cnt = 0, checked = 0;
   // each row: mask value, then sources {exp, mgmt_n, net, tx_half, rx_full, rx_half}
   logic [11:0] rows [9] = '{12'hfeb, 12'h014, 12'hf55, 12'hf57, 12'hdd0, 12'hbdc, 12'hbc4, 12'h7f4, 12'h834};
   assign {expansion_irq_i, mgmt_unit_irq_n_i, network_module_irq_i, tx_half_i, rx_full_i, rx_half_i} = src;
   always #25 clk_i = ~clk_i;
   nisl_top #(.WDOG_CYCLES(WD)) DUT (.*);
   nisl_host host (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
      .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
   function automatic logic [31:0] exp_st(input logic [5:0] m, input logic [5:0] s);
      logic ser, raw;
      ser = s[3] | ~s[4];
      raw = (s[0] & ~m[1]) | (~s[2] & ~m[3]) | (ser & ~m[4]) | (s[5] & ~m[5]);
      return {21'h0, raw, raw, s[5], ser, 4'h0, s[1], s[2], s[0]};
   endfunction
   task automatic summarize;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      host.xfer(we, a, d, q);
      if (host.tmo) begin
         error_cnt++;
         summarize();
      end
   endtask
   task automatic pulse(input logic dir);
      marker_count_enable_i <= 1'h1;
      marker_count_dir_i <= dir;
      @(posedge clk_i);
      marker_count_enable_i <= 1'h0;
      repeat (4) @(posedge clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      bus(1'h0, `NISL_OFS_CTRL, 32'h0);
      chk(q, 32'h0000_003f);
      $display("reset test done");
      foreach (rows[i]) begin
         bus(1'h1, `NISL_OFS_CTRL, {26'h0, rows[i][11:6]});
         src <= rows[i][5:0];
         repeat (4) @(posedge clk_i);
         bus(1'h0, `NISL_OFS_STAT, 32'h0);
         chk(q & 32'h0000_07ff, exp_st(rows[i][11:6], rows[i][5:0]));
      end
      $display("mask table done");
      src <= 6'h14;
      bus(1'h1, `NISL_OFS_CTRL, 32'h0000_003e);
      dram_rd_done_i <= 1'h1;
      byte_parity_ok_i <= 8'hfe;
      @(posedge clk_i);
      dram_rd_done_i <= 1'h0;
      byte_parity_ok_i <= 8'hff;
      repeat (4) @(posedge clk_i);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0450, 32'h0000_0450);
      bus(1'h1, `NISL_OFS_CLR, 32'h0000_0001);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0050, 32'h0000_0040);
      dram_rd_done_i <= 1'h1;
      @(posedge clk_i);
      dram_rd_done_i <= 1'h0;
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0040, 32'h0);
      $display("parity test done");
      bus_busy_i <= 1'h1;
      repeat (WD + 5) @(posedge clk_i);
      bus_busy_i <= 1'h0;
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0420, 32'h0000_0420);
      bus(1'h1, `NISL_OFS_CLR, 32'h0000_0002);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0020, 32'h0);
      bus_busy_i <= 1'h1;
      repeat (WD - 1) @(posedge clk_i);
      bus_busy_i <= 1'h0;
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0020, 32'h0);
      $display("timeout test done");
      bus(1'h1, `NISL_OFS_CTRL, 32'h0000_003d);
      pulse(1'h1);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0408, 32'h0000_0008);
      bus(1'h1, `NISL_OFS_CTRL, 32'h0000_0039);
      // unmasked marker needs two sync edges before the cpu bit shows
      repeat (2) @(posedge clk_i);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0408, 32'h0000_0408);
      pulse(1'h0);
      pulse(1'h0);
      bus(1'h0, `NISL_OFS_STAT, 32'h0);
      chk(q & 32'h0000_0408, 32'h0);
      bus(1'h0, 8'h0c, 32'h0);
      chk(q, 32'h0);
      $display("marker test done");
      summarize();
   end
endmodule
bind nisl_top nisl_chk #(.WDOG_CYCLES(WDOG_CYCLES), .MARK_W(MARK_W)) chk_i (.*);
`default_nettype wire
